//--- sim/indexed_stack_ops_exec_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((e) !== (a)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", n, e, a); end end
module indexed_stack_ops_exec_tb;
  import isx_pkg::*;
  logic                clk_i = 0, rst_n_i = 0, ce_i = 1;
  logic                extended_set_enable_i = 0, insn_valid_i = 0;
  logic [15:0]         insn_i = 0;
  logic [PC_W-1:0]     return_stack_top_i = 0, pc_value_o;
  logic [ADDR_W-1:0]   mem_raddr_o, mem_waddr_o, p[3];
  logic [DATA_W-1:0]   mem_wdata_o;
  logic                mem_we_o, pc_load_o, return_pop_o, busy_o, status_we_o;
  logic [3*ADDR_W-1:0] ptrs_o;
  wire  [DATA_W-1:0]   mem_rdata_i = mem_raddr_o[7:0] ^ 8'h5a;
  logic [21:0]         exp_q[$], e;
  int                  bad_count = 0, n_compared = 0;
  isx_exec dut (.clk_i, .rst_n_i, .ce_i, .extended_set_enable_i, .insn_valid_i,
    .insn_i, .mem_rdata_i, .return_stack_top_i, .mem_raddr_o, .mem_we_o,
    .mem_waddr_o, .mem_wdata_o, .pc_load_o, .pc_value_o, .return_pop_o,
    .busy_o, .status_we_o, .ptrs_o);
  always #5 clk_i = ~clk_i;
  // Results are looked at mid-cycle, where the registered pulses are settled
  always @(negedge clk_i) begin
    if (mem_we_o || pc_load_o) begin
      `CHK("notes", 1'b1, exp_q.size() != 0)
      e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
    end
    if (mem_we_o) `CHK("write", e, {2'h0, mem_waddr_o, mem_wdata_o})
    if (pc_load_o) `CHK("pc", e, {1'b1, pc_value_o})
    if (pc_load_o) `CHK("pop", 1'b1, return_pop_o)
  end
  task op(input logic [15:0] w);
    insn_i = w;
    insn_valid_i = 1;
    @(posedge clk_i);
    #1;
  endtask
  task idle();
    insn_valid_i = 0;
    @(posedge clk_i);
    #1;
  endtask
  task push(input logic [7:0] k);
    exp_q.push_back({2'h0, p[2], k});
    p[2] = p[2] - 12'h001;
    op({OP_PUSH_LIT, k});
  endtask
  task sub(input logic [1:0] f, input logic [5:0] k);
    op({OP_SUB_PTR, f, k});
    if (f == SEL_RETURN) begin
      exp_q.push_back({1'b1, return_stack_top_i});
      p[2] = p[2] - 12'(k);
      `CHK("busy", 1'b1, busy_o)
      idle();
      `CHK("busy", 1'b0, busy_o)
    end else p[f] = p[f] - 12'(k);
  endtask
  // Word two carries random filler in the bits the decoder ignores
  task move(input logic [6:0] zs, input logic [6:0] zd);
    logic [11:0] s, d;
    s = p[2] + 12'(zs);
    d = p[2] + 12'(zd);
    if (!(d >= IND_LO && d <= IND_HI)) exp_q.push_back({2'h0, d,
      (s >= IND_LO && s <= IND_HI) ? ZERO_B : s[7:0] ^ 8'h5a});
    op({OP_MOVE_IDX, 1'b1, zs});
    op({OP_SECOND, 4'($urandom), 1'($urandom), zd});
  endtask
  task final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    final_report();
  end
  initial begin
    void'($urandom(47858));
    p = '{default: PTR_RESET};
    repeat (10) @(posedge clk_i);
    #1 rst_n_i = 1;
    op({OP_PUSH_LIT, 8'h11});
    op({OP_SUB_PTR, 8'hc5});
    idle();
    `CHK("ptrs", 36'h0, ptrs_o)
    $display("disabled test done");
    extended_set_enable_i = 1;
    sub(2'h2, 6'h3f);
    move(7'h1a, 7'h2f);
    move(7'h10, 7'h2e);
    move(7'h2e, 7'h00);
    // Random destinations stay low in the frame, clear of the control bytes
    repeat (4) move(7'($urandom), 7'($urandom % 32));
    push(8'h5c);
    `CHK("ptrs", {p[2], p[1], p[0]}, ptrs_o)
    $display("move test done");
    repeat (5) push(8'($urandom));
    `CHK("ptrs", {p[2], p[1], p[0]}, ptrs_o)
    // A push offered while the enable is low must leave no trace
    idle();
    ce_i = 0;
    op({OP_PUSH_LIT, 8'h77});
    ce_i = 1;
    idle();
    `CHK("ptrs", {p[2], p[1], p[0]}, ptrs_o)
    $display("push test done");
    for (int f = 0; f < 8; f++) begin
      return_stack_top_i = 21'($urandom);
      sub(2'(f), 6'($urandom));
    end
    sub(2'h0, 6'h3f);
    `CHK("ptrs", {p[2], p[1], p[0]}, ptrs_o)
    $display("subtract test done");
    idle();
    idle();
    `CHK("left", 0, exp_q.size())
    final_report();
  end
endmodule // indexed_stack_ops_exec_tb

//--- sim/isx_exec_assertions.sv
`timescale 1ns/100ps
module isx_exec_chk
  import isx_pkg::*;
(
  // Inputs of the block
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                ce_i,
  input wire logic                extended_set_enable_i,
  input wire logic                insn_valid_i,
  input wire logic [15:0]         insn_i,
  input wire logic [PC_W-1:0]     return_stack_top_i,
  // Outputs of the block
  input wire logic                mem_we_o,
  input wire logic [ADDR_W-1:0]   mem_waddr_o,
  input wire logic [DATA_W-1:0]   mem_wdata_o,
  input wire logic                pc_load_o,
  input wire logic [PC_W-1:0]     pc_value_o,
  input wire logic                return_pop_o,
  input wire logic                busy_o,
  input wire logic                status_we_o,
  input wire logic [3*ADDR_W-1:0] ptrs_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Opening words count only while no two-cycle operation is under way
  wire go  = ce_i && !busy_o && insn_valid_i && extended_set_enable_i;
  wire psh = go && insn_i[15:8] == OP_PUSH_LIT;
  wire sub = go && insn_i[15:8] == OP_SUB_PTR;
  wire ret = sub && insn_i[7:6] == SEL_RETURN;
  wire [ADDR_W-1:0] fp = ptrs_o[35:24];
  wire sec = ce_i && busy_o && insn_valid_i && insn_i[15:12] == OP_SECOND;
  wire [ADDR_W-1:0] dst = fp + 12'(insn_i[6:0]);
  a_move_nop:
  assert property (sec && dst >= IND_LO && dst <= IND_HI |=> !mem_we_o)
    else $error("move to indirect register wrote");
  a_ret_busy:
  assert property (ret |=> busy_o ##1 !busy_o)
    else $error("return busy wrong");
  a_push_write:
  assert property (psh |=> mem_we_o && mem_waddr_o == $past(fp)
    && mem_wdata_o == $past(insn_i[7:0])) else $error("push write wrong");
  a_push_decr:
  assert property (psh |=> fp == $past(fp) - 12'h001) else $error("push ptr");
  a_sub_ptr:
  assert property (sub && !ret |=> ptrs_o[$past(insn_i[7:6])*12 +: 12] ==
    $past(ptrs_o[insn_i[7:6]*12 +: 12]) - $past(insn_i[5:0]))
    else $error("pointer subtract wrong");
  a_ret_frame:
  assert property (ret |=> fp == $past(fp) - $past(insn_i[5:0]))
    else $error("return frame wrong");
  a_ret_load:
  assert property (ret |=> pc_load_o && return_pop_o
    && pc_value_o == $past(return_stack_top_i))
    else $error("return load wrong");
  a_ret_idle:
  assert property (ret |=> !mem_we_o ##1 !pc_load_o && !mem_we_o)
    else $error("return second cycle busy");
  a_off_quiet:
  assert property (!extended_set_enable_i && !busy_o |=> !mem_we_o
    && !pc_load_o
    && $stable(ptrs_o)) else $error("disabled op ran");
  a_no_status:
  assert property (go |-> status_we_o == 1'b0) else $error("status written");
endmodule // isx_exec_chk
bind isx_exec isx_exec_chk u_chk (.clk_i, .rst_n_i, .ce_i,
  .extended_set_enable_i, .insn_valid_i, .insn_i, .return_stack_top_i,
  .mem_we_o, .mem_waddr_o, .mem_wdata_o, .pc_load_o, .pc_value_o,
  .return_pop_o, .busy_o, .status_we_o, .ptrs_o);

//--- verilog/isx_exec.sv
`timescale 1ns/100ps
module isx_exec
  import isx_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Configuration
  input  wire logic              extended_set_enable_i,
  // Instruction stream, one word per instruction cycle
  input  wire logic              insn_valid_i,
  input  wire logic [15:0]       insn_i,
  // Data memory read result for address mem_raddr_o, same cycle
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  // Return stack top
  input  wire logic [PC_W-1:0]   return_stack_top_i,
  // Data memory
  output logic [ADDR_W-1:0]      mem_raddr_o,
  output logic                   mem_we_o,
  output logic [ADDR_W-1:0]      mem_waddr_o,
  output logic [DATA_W-1:0]      mem_wdata_o,
  // Control flow
  output logic                   pc_load_o,
  output logic [PC_W-1:0]        pc_value_o,
  output logic                   return_pop_o,
  output logic                   busy_o,
  output logic                   status_we_o,
  // Pointer registers
  output logic [3*ADDR_W-1:0]    ptrs_o
);
  isx_ptr_if pif();
  isx_ptr_file u_ptrs (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .pf      (pif.file)
  );

  // ****************************************
  // Instruction decode
  // ****************************************
  logic [7:0]        opc;
  logic [1:0]        fsel;
  logic [ADDR_W-1:0] fp;
  logic [ADDR_W-1:0] sel_ptr;
  logic [ADDR_W-1:0] src_a;
  logic [ADDR_W-1:0] dst_a;
  logic [ADDR_W-1:0] lit6;
  logic              go;
  logic              dec_move;
  logic              dec_push;
  logic              dec_sub;
  logic              dec_ret;
  logic              dec_second;

  function automatic logic is_ind(input logic [ADDR_W-1:0] a);
    return (a >= IND_LO) && (a <= IND_HI);
  endfunction

  assign opc  = insn_i[OPC_MSB:OPC_LSB];
  assign fsel = insn_i[SEL_MSB:SEL_LSB];
  assign lit6 = ADDR_W'(insn_i[LIT6_W-1:0]);
  assign fp   = pif.ptrs[N_PTR*ADDR_W-1 -: ADDR_W];

  // Loop instead of an indexed slice: selector 3 must not read past the end
  always_comb begin
    sel_ptr = fp;
    for (int i = 0; i < N_PTR; i++) begin
      if (fsel == 2'(i)) begin
        sel_ptr = pif.ptrs[i*ADDR_W +: ADDR_W];
      end
    end
  end

  // Sums keep 12 bits, so offsets wrap inside the 4 KB space
  assign src_a = fp + ADDR_W'(insn_i[OFS_W-1:0]); // RQ2 RQ3
  assign dst_a = fp + ADDR_W'(insn_i[OFS_W-1:0]); // RQ2 RQ3
  // A cleared enable makes every opening word inert
  assign go    = insn_valid_i && extended_set_enable_i; // RQ1

  assign dec_move = go && opc == OP_MOVE_IDX && insn_i[IDX_BIT];
  assign dec_push = go && opc == OP_PUSH_LIT; // RQ7
  assign dec_sub  = go && opc == OP_SUB_PTR; // RQ10
  assign dec_ret  = dec_sub && fsel == SEL_RETURN; // RQ11
  // Word two is known by its group nibble; its middle bits are free
  assign dec_second = insn_valid_i &&
                      insn_i[OPC_MSB:GRP_LSB] == OP_SECOND;

  // ****************************************
  // Sequencing
  // ****************************************
  isx_state_e st_q, st_d;
  logic       busy_q, busy_d;

  always_comb begin
    st_d   = st_q;
    busy_d = 1'b0;
    case (st_q)
      ISX_IDLE: begin
        if (dec_move) begin
          busy_d = 1'b1;
          st_d   = ISX_MOVE2;
        end else if (dec_ret) begin
          busy_d = 1'b1;
          st_d   = ISX_RET2; // RQ13
        end
      end
      ISX_MOVE2: begin
        // Parks here until word two turns up
        if (dec_second) begin
          st_d = ISX_IDLE;
        end else begin
          busy_d = 1'b1;
        end
      end
      ISX_RET2: begin
        // Bubble cycle: whatever word stands here is dropped
        st_d = ISX_IDLE; // RQ13
      end
      default: begin
        st_d = ISX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q   <= ISX_IDLE;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      st_q   <= st_d;
      busy_q <= busy_d;
    end
  end

  // ****************************************
  // Data memory port
  // ****************************************
  logic [ADDR_W-1:0] raddr_q, raddr_d;
  logic              we_q, we_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;

  // The source address is registered on word one and read while word two
  // stands; the read port then never sees a decode glitch
  always_comb begin
    raddr_d = raddr_q;
    we_d    = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    case (st_q)
      ISX_IDLE: begin
        if (dec_move) begin
          raddr_d = src_a;
        end else if (dec_push) begin
          we_d    = 1'b1; // RQ7
          waddr_d = fp;
          wdata_d = insn_i[DATA_W-1:0];
        end
      end
      ISX_MOVE2: begin
        if (dec_second) begin
          // Program counter and return-top bytes are not fenced off here
          we_d    = !is_ind(dst_a); // RQ6
          waddr_d = dst_a;
          wdata_d = is_ind(raddr_q) ? ZERO_B : mem_rdata_i; // RQ5
        end
      end
      default: begin
        we_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      raddr_q <= PTR_RESET;
      we_q    <= 1'b0;
      waddr_q <= PTR_RESET;
      wdata_q <= ZERO_B;
    end else if (ce_i) begin
      raddr_q <= raddr_d;
      we_q    <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  // ****************************************
  // Control flow and status
  // ****************************************
  logic            pcl_q, pcl_d;
  logic [PC_W-1:0] pcv_q, pcv_d;
  logic            status_we_q, status_we_d;

  always_comb begin
    pcl_d       = 1'b0;
    pcv_d       = pcv_q;
    // Pointer arithmetic never reports carry, zero or overflow
    status_we_d = 1'b0; // RQ14
    if (st_q == ISX_IDLE && dec_ret) begin
      pcl_d = 1'b1; // RQ12
      pcv_d = return_stack_top_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pcl_q       <= 1'b0;
      pcv_q       <= '0;
      status_we_q <= 1'b0;
    end else if (ce_i) begin
      pcl_q       <= pcl_d;
      pcv_q       <= pcv_d;
      status_we_q <= status_we_d;
    end
  end

  // ****************************************
  // Pointer update request
  // ****************************************
  always_comb begin
    pif.we  = 1'b0;
    pif.sel = FP_SEL;
    pif.val = fp;
    if (st_q == ISX_IDLE) begin
      if (dec_push) begin
        pif.we  = 1'b1;
        pif.val = fp - PTR_ONE; // RQ8
      end else if (dec_ret) begin
        pif.we  = 1'b1;
        pif.val = fp - lit6; // RQ11
      end else if (dec_sub) begin
        pif.we  = 1'b1;
        pif.sel = fsel;
        pif.val = sel_ptr - lit6; // RQ9
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mem_raddr_o  = raddr_q;
  assign mem_we_o     = we_q;
  assign mem_waddr_o  = waddr_q;
  assign mem_wdata_o  = wdata_q;
  assign pc_load_o    = pcl_q;
  assign pc_value_o   = pcv_q;
  assign return_pop_o = pcl_q;
  assign busy_o       = busy_q;
  assign status_we_o  = status_we_q; // RQ14
  assign ptrs_o       = pif.ptrs;
endmodule // isx_exec

//--- verilog/isx_pkg.sv
// What this block does
// RQ1: Extended operations execute only when the extended-set enable bit is set.
// RQ2: Indexed move forms both addresses as frame pointer plus 7-bit offsets.
// RQ3: Indexed move addresses may fall anywhere in the 4096-byte data space.
// RQ4: Software must not target program counter low or return-top bytes.
// RQ5: Source address on an indirect register moves value 00h.
// RQ6: Destination address on an indirect register makes the move a no-op.
// RQ7: Push-literal stores its 8-bit value at frame pointer, one word, one cycle.
// RQ8: After push-literal the frame pointer decrements by exactly one.
// RQ9: Subtract-from-pointer subtracts 6-bit value from pointer 0, 1 or 2.
// RQ10: Subtract-from-pointer upper byte is 1110 1001, selector 7:6, value 5:0.
// RQ11: Selector 11 decodes as subtract-and-return on the frame pointer.
// RQ12: Subtract-and-return then loads program counter from return stack top.
// RQ13: Subtract-and-return takes two cycles, the second doing nothing.
// RQ14: No operation here changes arithmetic status flags.
package isx_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W   = 21;
  localparam int OFS_W  = 7;
  localparam int LIT6_W = 6;
  localparam int N_PTR   = 3;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 8;
  localparam int GRP_LSB = 12;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 6;
  localparam int IDX_BIT = 7;
  localparam logic [1:0] FP_SEL = 2'h2;
  localparam logic [7:0] OP_MOVE_IDX  = 8'heb;
  localparam logic [3:0] OP_SECOND    = 4'hf;
  localparam logic [7:0] OP_PUSH_LIT  = 8'hfa;
  localparam logic [7:0] OP_SUB_PTR   = 8'he9;
  localparam logic [1:0] SEL_RETURN   = 2'h3;
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] PTR_ONE   = 12'h001;
  // Indirect addressing registers occupy fixed high SFR slots
  localparam logic [ADDR_W-1:0] IND_LO  = 12'hfdb;
  localparam logic [ADDR_W-1:0] IND_HI  = 12'hfef;
  localparam logic [DATA_W-1:0] ZERO_B  = 8'h00;
  typedef enum logic [1:0] {ISX_IDLE, ISX_MOVE2, ISX_RET2} isx_state_e;
endpackage

//--- verilog/isx_ptr_file.sv
`timescale 1ns/100ps
module isx_ptr_file
  import isx_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  isx_ptr_if.file   pf
);
  logic [ADDR_W-1:0] ptr_q [N_PTR];
  logic [ADDR_W-1:0] ptr_d [N_PTR];

  always_comb begin
    for (int i = 0; i < N_PTR; i++) begin
      ptr_d[i] = ptr_q[i];
      if (pf.we && pf.sel == 2'(i)) begin
        ptr_d[i] = pf.val;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < N_PTR; i++) begin
      if (!rst_n_i) begin
        ptr_q[i] <= PTR_RESET;
      end else if (ce_i) begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  assign pf.ptrs = {ptr_q[2], ptr_q[1], ptr_q[0]};
endmodule // isx_ptr_file

//--- verilog/isx_ptr_if.sv
`timescale 1ns/100ps
// Pointer update request between decoder and pointer file
interface isx_ptr_if;
  logic                  we;
  logic [1:0]            sel;
  logic [isx_pkg::ADDR_W-1:0]                val;
  logic [isx_pkg::N_PTR*isx_pkg::ADDR_W-1:0] ptrs;
  modport ctl (output we, output sel, output val, input ptrs);
  modport file (input we, input sel, input val, output ptrs);
endinterface
